// *** tscr_regs.sv ***
/*
  Processor-status register bank of one tile: tile control with the RGMII
  transmit clock generator and the low-power clock divider, boot status,
  the OTP-loaded security word and ring oscillator control and counts.
  Assumes i_clk is the PLL output clock that also clocks the core, and that
  every input but i_ring_osc is synchronous to it.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - 8-bit RGMII transmit data delay, resets zero.
// - TX clock rises at divider, falls at half.
// - RGMII port enable bit enables RGMII ports.
// - Divider enable bit divides PLL clock.
// - Dynamic mode divides only while threads paused.
// - USB mode bit: one UTMI, zero ULPI.
// - ULPI support bit enables ULPI helper.
// - Boot status read-only, processor number 23:16.
// - Boot status shows JTAG, RAM, PLL pins.
// - Boot status bit 5 shows core1 off.
// - Boot status bit 4 shows skip OTP poll.
// - Security top bit set blocks further writes.
// - Security bit 14 blocks global debug.
// - Bit 12 locks all OTP, 11:8 each.
// - Security bit 5 forces boot from OTP.
// - Security bit 4 refuses JTAG config access.
// - Security bit 0 blocks JTAG debug TAP.
// - Security word loads from OTP read-out.
// - Four oscillators, bit 1 core, bit 0 peripheral.
// - Oscillators run asynchronous, counts give random bits.
// - Sixteen-bit counters survive system reset.
module tscr_regs
  import tscr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_ps_wr,
  input wire logic i_ps_rd,
  input wire logic [TSCR_AW-1:0] i_ps_addr,
  input wire logic [TSCR_DW-1:0] i_ps_wdata,
  output logic [TSCR_DW-1:0] o_ps_rdata,
  output logic o_ps_rvalid,
  output logic o_ps_wr_refused,
  input wire logic [7:0] i_proc_num,
  input wire logic i_boot_overwrite,
  input wire logic i_core1_off,
  input wire logic i_skip_otp_poll,
  input wire logic i_boot_ram,
  input wire logic i_boot_jtag,
  input wire logic [1:0] i_boot_pll_mode,
  input wire logic i_otp_load,
  input wire logic [TSCR_DW-1:0] i_otp_sec_word,
  input wire logic i_all_paused,
  input wire logic [ROC_NUM-1:0] i_ring_osc,
  output logic [ROC_NUM-1:0] o_ring_osc_en,
  output logic o_rgmii_txc,
  output logic o_rgmii_txd_launch,
  output logic [7:0] o_rgmii_txd_delay,
  output logic o_rgmii_en,
  output logic o_core_clk_en,
  output logic o_usb_utmi_mode,
  output logic o_ulpi_helper_en,
  output logic o_global_debug_block,
  output logic [3:0] o_otp_sector_lock,
  output logic o_otp_redundancy_en,
  output logic o_boot_from_otp,
  output logic o_jtag_cfg_block,
  output logic o_jtag_tap_block
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write and read paths.
  function automatic logic tscr_hit(input logic [TSCR_AW-1:0] addr, input logic [TSCR_AW-1:0] reg_num);
    tscr_hit = (addr == reg_num);
  endfunction

  function automatic logic tscr_is_roc_val(input logic [TSCR_AW-1:0] addr);
    tscr_is_roc_val = (addr >= TSCR_REG_ROC_VAL0) && (addr <= TSCR_REG_ROC_VAL3);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [31:0] tile_ctrl_r;
  logic [31:0] tile_ctrl_nxt;
  logic [31:0] sec_cfg_r;
  logic [31:0] sec_cfg_nxt;
  logic [31:0] roc_ctrl_r;
  logic [31:0] roc_ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic refused_r;
  logic refused_nxt;
  logic strap_done_r;
  logic strap_done_nxt;
  logic [1:0] pll_mode_r;
  logic [1:0] pll_mode_nxt;
  logic [31:0] boot_word;
  logic [1:0] roc_sel;

  tscr_roc_if roc_bus ();

  tscr_roc_counters u_roc (
    .i_clk(i_clk),
    .i_por(i_por),
    .i_ring_osc(i_ring_osc),
    .roc(roc_bus.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Boot status is assembled from live status inputs plus the PLL mode pins,
  // which are caught once on the first edge after reset release.
  always_comb begin
    strap_done_nxt = 1'b1;
    pll_mode_nxt = pll_mode_r;
    if (!strap_done_r) begin
      pll_mode_nxt = i_boot_pll_mode;
    end
  end

  always_comb begin
    boot_word = 32'h0000_0000;
    boot_word[BS_PROC_MSB:BS_PROC_LSB] = i_proc_num;
    boot_word[BS_OVERWRITE_BIT] = i_boot_overwrite;
    boot_word[BS_CORE1_OFF_BIT] = i_core1_off;
    boot_word[BS_SKIP_POLL_BIT] = i_skip_otp_poll;
    boot_word[BS_BOOT_RAM_BIT] = i_boot_ram;
    boot_word[BS_BOOT_JTAG_BIT] = i_boot_jtag;
    boot_word[BS_PLL_MODE_MSB:0] = pll_mode_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writes. The boot status has no write path at all.
  always_comb begin
    tile_ctrl_nxt = tile_ctrl_r;
    roc_ctrl_nxt = roc_ctrl_r;
    sec_cfg_nxt = sec_cfg_r;
    refused_nxt = 1'b0;
    if (i_ps_wr && tscr_hit(i_ps_addr, TSCR_REG_TILE_CTRL)) begin
      tile_ctrl_nxt = i_ps_wdata & TC_WMASK;
    end
    if (i_ps_wr && tscr_hit(i_ps_addr, TSCR_REG_ROC_CTRL)) begin
      roc_ctrl_nxt = i_ps_wdata & RC_WMASK;
    end
    // An OTP load always wins: it is how a locked word gets its contents.
    if (i_otp_load) begin
      sec_cfg_nxt = i_otp_sec_word & SC_WMASK;
    end else if (i_ps_wr && tscr_hit(i_ps_addr, TSCR_REG_SEC_CFG)) begin
      if (sec_cfg_r[SC_WLOCK_BIT]) begin
        refused_nxt = 1'b1;
      end else begin
        sec_cfg_nxt = i_ps_wdata & SC_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reads answer one cycle later from a register; unmapped numbers give zero.
  assign roc_sel = 2'(i_ps_addr - TSCR_REG_ROC_VAL0);

  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = i_ps_rd;
    if (i_ps_rd) begin
      rdata_nxt = 32'h0000_0000;
      if (tscr_hit(i_ps_addr, TSCR_REG_TILE_CTRL)) begin
        rdata_nxt = tile_ctrl_r;
      end else if (tscr_hit(i_ps_addr, TSCR_REG_BOOT_STAT)) begin
        rdata_nxt = boot_word;
      end else if (tscr_hit(i_ps_addr, TSCR_REG_SEC_CFG)) begin
        rdata_nxt = sec_cfg_r;
      end else if (tscr_hit(i_ps_addr, TSCR_REG_ROC_CTRL)) begin
        rdata_nxt = roc_ctrl_r;
      end else if (tscr_is_roc_val(i_ps_addr)) begin
        rdata_nxt = {16'h0000, roc_bus.count[roc_sel]};
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tile_ctrl_r <= TC_RESET;
      sec_cfg_r <= SC_RESET;
      roc_ctrl_r <= RC_RESET;
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
      refused_r <= 1'b0;
      strap_done_r <= 1'b0;
      pll_mode_r <= 2'h0;
    end else begin
      tile_ctrl_r <= tile_ctrl_nxt;
      sec_cfg_r <= sec_cfg_nxt;
      roc_ctrl_r <= roc_ctrl_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      refused_r <= refused_nxt;
      strap_done_r <= strap_done_nxt;
      pll_mode_r <= pll_mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RGMII transmit clock generator. The counter wraps after the divider
  // value, so a field of N gives a period of N+1 PLL cycles.
  logic [8:0] txc_div;
  logic [7:0] txd_dly;
  logic rgmii_on;
  logic [8:0] txc_cnt_r;
  logic [8:0] txc_cnt_nxt;
  logic txc_r;
  logic txc_nxt;
  logic [7:0] dly_cnt_r;
  logic [7:0] dly_cnt_nxt;
  logic dly_busy_r;
  logic dly_busy_nxt;
  logic launch_r;
  logic launch_nxt;

  assign txc_div = tile_ctrl_r[TC_TXC_DIV_MSB:TC_TXC_DIV_LSB];
  assign txd_dly = tile_ctrl_r[TC_TXD_DLY_MSB:TC_TXD_DLY_LSB];
  assign rgmii_on = tile_ctrl_r[TC_RGMII_EN_BIT];

  always_comb begin
    txc_cnt_nxt = 9'h000;
    txc_nxt = 1'b0;
    if (rgmii_on) begin
      txc_nxt = txc_r;
      if (txc_cnt_r == txc_div) begin
        txc_cnt_nxt = 9'h000;
        txc_nxt = 1'b1;
      end else begin
        txc_cnt_nxt = txc_cnt_r + 9'h001;
        if (txc_cnt_r == (txc_div >> 1)) begin
          txc_nxt = 1'b0;
        end
      end
    end
  end

  // Each rising edge starts a delay of one PLL cycle more than the programmed count
  // before data launch; a new edge restarts a delay still running.
  always_comb begin
    dly_cnt_nxt = dly_cnt_r;
    dly_busy_nxt = dly_busy_r;
    launch_nxt = 1'b0;
    if (!rgmii_on) begin
      dly_cnt_nxt = 8'h00;
      dly_busy_nxt = 1'b0;
    end else if (txc_cnt_r == txc_div) begin
      dly_cnt_nxt = txd_dly;
      dly_busy_nxt = 1'b1;
    end else if (dly_busy_r) begin
      if (dly_cnt_r == 8'h00) begin
        launch_nxt = 1'b1;
        dly_busy_nxt = 1'b0;
      end else begin
        dly_cnt_nxt = dly_cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      txc_cnt_r <= 9'h000;
      txc_r <= 1'b0;
      dly_cnt_r <= 8'h00;
      dly_busy_r <= 1'b0;
      launch_r <= 1'b0;
    end else begin
      txc_cnt_r <= txc_cnt_nxt;
      txc_r <= txc_nxt;
      dly_cnt_r <= dly_cnt_nxt;
      dly_busy_r <= dly_busy_nxt;
      launch_r <= launch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power divider. It emits a clock enable rather than a new clock, so
  // the core stays on one clock tree and no glitch can reach it.
  logic lp_active;
  logic [LP_CW-1:0] lp_cnt_r;
  logic [LP_CW-1:0] lp_cnt_nxt;
  logic clk_en_r;
  logic clk_en_nxt;

  assign lp_active = tile_ctrl_r[TC_DIV_EN_BIT] && (!tile_ctrl_r[TC_DYN_BIT] || i_all_paused);

  always_comb begin
    lp_cnt_nxt = {LP_CW{1'b0}};
    clk_en_nxt = 1'b1;
    if (lp_active) begin
      clk_en_nxt = (lp_cnt_r == {LP_CW{1'b0}});
      lp_cnt_nxt = (lp_cnt_r == LP_LAST) ? {LP_CW{1'b0}} : lp_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lp_cnt_r <= {LP_CW{1'b0}};
      clk_en_r <= 1'b1;
    end else begin
      lp_cnt_r <= lp_cnt_nxt;
      clk_en_r <= clk_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. Counts must only be trusted once the oscillators have been
  // stopped for ten cycles, which covers the synchroniser and counter delay.
  assign roc_bus.run[0] = roc_ctrl_r[RC_CORE_BIT];
  assign roc_bus.run[1] = roc_ctrl_r[RC_CORE_BIT];
  assign roc_bus.run[2] = roc_ctrl_r[RC_PERIPH_BIT];
  assign roc_bus.run[3] = roc_ctrl_r[RC_PERIPH_BIT];
  assign o_ring_osc_en = roc_bus.run;

  assign o_ps_rdata = rdata_r;
  assign o_ps_rvalid = rvalid_r;
  assign o_ps_wr_refused = refused_r;
  assign o_rgmii_txc = txc_r;
  assign o_rgmii_txd_launch = launch_r;
  assign o_rgmii_txd_delay = txd_dly;
  assign o_rgmii_en = rgmii_on;
  assign o_core_clk_en = clk_en_r;
  assign o_usb_utmi_mode = tile_ctrl_r[TC_UTMI_BIT];
  assign o_ulpi_helper_en = tile_ctrl_r[TC_ULPI_BIT];
  assign o_global_debug_block = sec_cfg_r[SC_GDBG_BIT];
  assign o_otp_sector_lock = sec_cfg_r[SC_OTP_SEC_MSB:SC_OTP_SEC_LSB] | {4{sec_cfg_r[SC_OTP_ALL_BIT]}};
  assign o_otp_redundancy_en = sec_cfg_r[SC_OTP_RED_BIT];
  assign o_boot_from_otp = sec_cfg_r[SC_OTP_BOOT_BIT];
  assign o_jtag_cfg_block = sec_cfg_r[SC_JTAG_CFG_BIT];
  assign o_jtag_tap_block = sec_cfg_r[SC_JTAG_TAP_BIT];

endmodule

// *** tscr_pkg.sv ***
/*
  Constants for the tile status and configuration register bank: register
  numbers, field positions, write masks, reset values and divider counts.
  Assumes it is compiled before every other file of the block.
*/
package tscr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned TSCR_AW = 8;
  localparam int unsigned TSCR_DW = 32;
  localparam logic [7:0] TSCR_REG_TILE_CTRL = 8'h02;
  localparam logic [7:0] TSCR_REG_BOOT_STAT = 8'h03;
  localparam logic [7:0] TSCR_REG_SEC_CFG = 8'h05;
  localparam logic [7:0] TSCR_REG_ROC_CTRL = 8'h06;
  localparam logic [7:0] TSCR_REG_ROC_VAL0 = 8'h07;
  localparam logic [7:0] TSCR_REG_ROC_VAL3 = 8'h0A;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned TC_TXD_DLY_LSB = 18;
  localparam int unsigned TC_TXD_DLY_MSB = 25;
  localparam int unsigned TC_TXC_DIV_LSB = 9;
  localparam int unsigned TC_TXC_DIV_MSB = 17;
  localparam int unsigned TC_RGMII_EN_BIT = 8;
  localparam int unsigned TC_DYN_BIT = 5;
  localparam int unsigned TC_DIV_EN_BIT = 4;
  localparam int unsigned TC_UTMI_BIT = 2;
  localparam int unsigned TC_ULPI_BIT = 1;
  localparam logic [31:0] TC_WMASK = 32'h03FF_FF36;
  localparam logic [31:0] TC_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned BS_PROC_LSB = 16;
  localparam int unsigned BS_PROC_MSB = 23;
  localparam int unsigned BS_OVERWRITE_BIT = 8;
  localparam int unsigned BS_CORE1_OFF_BIT = 5;
  localparam int unsigned BS_SKIP_POLL_BIT = 4;
  localparam int unsigned BS_BOOT_RAM_BIT = 3;
  localparam int unsigned BS_BOOT_JTAG_BIT = 2;
  localparam int unsigned BS_PLL_MODE_MSB = 1;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned SC_WLOCK_BIT = 31;
  localparam int unsigned SC_GDBG_BIT = 14;
  localparam int unsigned SC_OTP_ALL_BIT = 12;
  localparam int unsigned SC_OTP_SEC_LSB = 8;
  localparam int unsigned SC_OTP_SEC_MSB = 11;
  localparam int unsigned SC_OTP_RED_BIT = 7;
  localparam int unsigned SC_OTP_BOOT_BIT = 5;
  localparam int unsigned SC_JTAG_CFG_BIT = 4;
  localparam int unsigned SC_JTAG_TAP_BIT = 0;
  localparam logic [31:0] SC_WMASK = 32'h8000_5FB1;
  localparam logic [31:0] SC_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned RC_CORE_BIT = 1;
  localparam int unsigned RC_PERIPH_BIT = 0;
  localparam logic [31:0] RC_WMASK = 32'h0000_0003;
  localparam logic [31:0] RC_RESET = 32'h0000_0000;
  localparam int unsigned ROC_NUM = 4;
  localparam int unsigned ROC_CW = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Low-power divide ratio of the PLL clock; the divider gates all but one
  // cycle in this many.
  localparam int unsigned LP_DIV = 2;
  localparam int unsigned LP_CW = 4;
  localparam logic [LP_CW-1:0] LP_LAST = LP_CW'(LP_DIV - 1);

  typedef logic [ROC_CW-1:0] tscr_count_t;

endpackage

// *** tscr_roc_if.sv ***
/*
  Carrier between the register bank and its ring oscillator counter bank:
  run enables one way, the synchronised counts the other.
  Assumes tscr_pkg is compiled first.
*/
`timescale 1ns/1ps
interface tscr_roc_if;
  import tscr_pkg::*;
  logic [ROC_NUM-1:0] run;
  tscr_count_t count [ROC_NUM];
  modport ctrl (output run, input count);
  modport cnt (input run, output count);
endinterface

// *** tscr_roc_counters.sv ***
/*
  Four ring oscillator counters. Each oscillator level is brought into the
  core clock domain by two flip-flops and its rising edges are counted while
  the oscillator runs. Assumes the oscillator outputs toggle slower than half
  the core clock rate and that i_por is only asserted at power-up.
*/
`timescale 1ns/1ps
module tscr_roc_counters
  import tscr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_por,
  input wire logic [ROC_NUM-1:0] i_ring_osc,
  tscr_roc_if.cnt roc
);

  ////////////////////////////////////////////////////////////////////////////
  // The counts hang off the power-on reset only, so a system reset leaves
  // them readable as a source of entropy.
  genvar g;
  generate
    for (g = 0; g < ROC_NUM; g = g + 1) begin : g_roc
      logic meta_r;
      logic sync_r;
      logic prev_r;
      tscr_count_t cnt_r;
      tscr_count_t cnt_nxt;

      always_comb begin
        cnt_nxt = cnt_r;
        if (roc.run[g] && sync_r && !prev_r) begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end

      always_ff @(posedge i_clk or posedge i_por) begin
        if (i_por) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
          cnt_r <= 16'h0000;
        end else begin
          meta_r <= i_ring_osc[g];
          sync_r <= meta_r;
          prev_r <= sync_r;
          cnt_r <= cnt_nxt;
        end
      end

      assign roc.count[g] = cnt_r;
    end
  endgenerate

endmodule

// *** tscr_regs_chk.sv ***
/*
  Concurrent checks on the ports of the tile status register bank.
  Assumes one clock domain, i_clk, and the asynchronous reset i_rst.
*/
`timescale 1ns/1ps
module tscr_regs_chk
  import tscr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ps_wr,
  input wire logic i_ps_rd,
  input wire logic [TSCR_AW-1:0] i_ps_addr,
  input wire logic [TSCR_DW-1:0] i_ps_wdata,
  input wire logic [TSCR_DW-1:0] o_ps_rdata,
  input wire logic o_ps_rvalid,
  input wire logic o_ps_wr_refused,
  input wire logic [7:0] i_proc_num,
  input wire logic i_boot_ram,
  input wire logic i_boot_jtag,
  input wire logic i_otp_load,
  input wire logic [TSCR_DW-1:0] i_otp_sec_word,
  input wire logic [ROC_NUM-1:0] o_ring_osc_en,
  input wire logic [7:0] o_rgmii_txd_delay,
  input wire logic o_rgmii_en,
  input wire logic o_core_clk_en,
  input wire logic o_usb_utmi_mode,
  input wire logic o_ulpi_helper_en,
  input wire logic o_global_debug_block,
  input wire logic [3:0] o_otp_sector_lock,
  input wire logic o_boot_from_otp,
  input wire logic o_jtag_cfg_block,
  input wire logic o_jtag_tap_block
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////////
  chk_ctrl_fields: assert property (i_ps_wr && i_ps_addr == TSCR_REG_TILE_CTRL |=>
    o_rgmii_txd_delay == $past(i_ps_wdata[25:18]) && o_rgmii_en == $past(i_ps_wdata[8]) &&
    o_usb_utmi_mode == $past(i_ps_wdata[2]) && o_ulpi_helper_en == $past(i_ps_wdata[1]))
    else $error("tile control fields not taken from write");
  chk_roc_enables: assert property (i_ps_wr && i_ps_addr == TSCR_REG_ROC_CTRL |=>
    o_ring_osc_en == {{2{$past(i_ps_wdata[0])}}, {2{$past(i_ps_wdata[1])}}})
    else $error("oscillator enables wrong");
  chk_otp_copy: assert property (i_otp_load |=> o_jtag_tap_block == $past(i_otp_sec_word[0]) &&
    o_jtag_cfg_block == $past(i_otp_sec_word[4]) && o_boot_from_otp == $past(i_otp_sec_word[5]) &&
    o_global_debug_block == $past(i_otp_sec_word[14]) &&
    o_otp_sector_lock == ($past(i_otp_sec_word[11:8]) | {4{$past(i_otp_sec_word[12])}}))
    else $error("security outputs differ from loaded word");
  chk_refuse_source: assert property (o_ps_wr_refused |-> $past(i_ps_wr) &&
    $past(i_ps_addr) == TSCR_REG_SEC_CFG) else $error("refusal without security write");
  chk_refuse_holds: assert property (o_ps_wr_refused && !$past(i_otp_load) |->
    $stable(o_jtag_tap_block) && $stable(o_boot_from_otp) && $stable(o_global_debug_block))
    else $error("refused write changed security outputs");
  chk_lp_gap: assert property (!o_core_clk_en |=> o_core_clk_en)
    else $error("core clock gated longer than one cycle");
  chk_read_answer: assert property (o_ps_rvalid == $past(i_ps_rd))
    else $error("read answer not one cycle after strobe");
  chk_boot_fields: assert property (o_ps_rvalid && $past(i_ps_addr) == TSCR_REG_BOOT_STAT |->
    o_ps_rdata[23:16] == $past(i_proc_num) && o_ps_rdata[3] == $past(i_boot_ram) &&
    o_ps_rdata[2] == $past(i_boot_jtag) && o_ps_rdata[31:24] == 8'h00 && o_ps_rdata[15:9] == 7'h00)
    else $error("boot status read wrong");
  chk_reserved_zero: assert property (o_ps_rvalid && $past(i_ps_addr) == TSCR_REG_TILE_CTRL |->
    (o_ps_rdata & ~TC_WMASK) == 32'h0000_0000) else $error("tile control reserved bits set");
  chk_count_width: assert property (o_ps_rvalid && $past(i_ps_addr) >= TSCR_REG_ROC_CTRL &&
    $past(i_ps_addr) <= TSCR_REG_ROC_VAL3 |-> o_ps_rdata[31:16] == 16'h0000)
    else $error("oscillator register upper bits set");

  cover property (o_ps_wr_refused);
  cover property (i_otp_load);
  cover property (!o_core_clk_en);
endmodule

bind tscr_regs tscr_regs_chk tscr_regs_chk_i (.i_clk(i_clk), .i_rst(i_rst), .i_ps_wr(i_ps_wr), .i_ps_rd(i_ps_rd),
  .i_ps_addr(i_ps_addr), .i_ps_wdata(i_ps_wdata), .o_ps_rdata(o_ps_rdata), .o_ps_rvalid(o_ps_rvalid),
  .o_ps_wr_refused(o_ps_wr_refused), .i_proc_num(i_proc_num), .i_boot_ram(i_boot_ram), .i_boot_jtag(i_boot_jtag),
  .i_otp_load(i_otp_load), .i_otp_sec_word(i_otp_sec_word), .o_ring_osc_en(o_ring_osc_en),
  .o_rgmii_txd_delay(o_rgmii_txd_delay), .o_rgmii_en(o_rgmii_en), .o_core_clk_en(o_core_clk_en),
  .o_usb_utmi_mode(o_usb_utmi_mode), .o_ulpi_helper_en(o_ulpi_helper_en),
  .o_global_debug_block(o_global_debug_block), .o_otp_sector_lock(o_otp_sector_lock),
  .o_boot_from_otp(o_boot_from_otp), .o_jtag_cfg_block(o_jtag_cfg_block), .o_jtag_tap_block(o_jtag_tap_block));

// *** tscr_regs_test.sv ***
/*
  Self-checking bench for the tile status register bank.
  Assumes the checker is bound in and a 25 MHz clock.
*/
`timescale 1ns/1ps
module tscr_regs_test;
  import tscr_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} tscr_row_t;
  logic i_clk = 1'b0, i_rst = 1'b1, i_por = 1'b1, i_ps_wr = 1'b0, i_ps_rd = 1'b0, i_otp_load = 1'b0;
  logic [7:0] i_ps_addr = 8'h00, i_proc_num = 8'hA5;
  logic [31:0] i_ps_wdata = 32'h0000_0000, i_otp_sec_word = 32'h0000_0000;
  logic i_boot_overwrite = 1'b1, i_core1_off = 1'b0, i_skip_otp_poll = 1'b1, i_boot_ram = 1'b0;
  logic i_boot_jtag = 1'b1, i_all_paused = 1'b0, refused;
  logic [1:0] i_boot_pll_mode = 2'h2;
  logic [3:0] i_ring_osc = 4'h0, o_ring_osc_en, o_otp_sector_lock;
  logic [7:0] o_rgmii_txd_delay;
  logic o_ps_rvalid, o_ps_wr_refused, o_rgmii_txc, o_rgmii_txd_launch, o_rgmii_en, o_core_clk_en;
  logic o_usb_utmi_mode, o_ulpi_helper_en, o_global_debug_block, o_otp_redundancy_en, o_boot_from_otp;
  logic o_jtag_cfg_block, o_jtag_tap_block;
  logic [31:0] o_ps_rdata;
  wire [31:0] sec_outs = {23'h0, o_global_debug_block, o_otp_sector_lock, o_otp_redundancy_en, o_boot_from_otp,
    o_jtag_cfg_block, o_jtag_tap_block};
  int miscompares = 0, checks_done = 0, cycles = 0, k, hi, lo, nl;
  tscr_row_t rows [9] = '{'{8'h02, 32'hFFFF_FFFF, 32'h03FF_FF36}, '{8'h02, 32'h0000_0000, 32'h0000_0000},
    '{8'h06, 32'hFFFF_FFFF, 32'h0000_0003}, '{8'h06, 32'h0000_0000, 32'h0000_0000},
    '{8'h03, 32'hFFFF_FFFF, 32'h00A5_0116}, '{8'h04, 32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h05, 32'h7FFF_FFFF, 32'h0000_5FB1}, '{8'h05, 32'h0000_0000, 32'h0000_0000},
    '{8'h07, 32'hFFFF_FFFF, 32'h0000_0000}};

  tscr_regs tscr_regs_i (.i_clk(i_clk), .i_rst(i_rst), .i_por(i_por), .i_ps_wr(i_ps_wr), .i_ps_rd(i_ps_rd),
    .i_ps_addr(i_ps_addr), .i_ps_wdata(i_ps_wdata), .o_ps_rdata(o_ps_rdata), .o_ps_rvalid(o_ps_rvalid),
    .o_ps_wr_refused(o_ps_wr_refused), .i_proc_num(i_proc_num), .i_boot_overwrite(i_boot_overwrite),
    .i_core1_off(i_core1_off), .i_skip_otp_poll(i_skip_otp_poll), .i_boot_ram(i_boot_ram),
    .i_boot_jtag(i_boot_jtag), .i_boot_pll_mode(i_boot_pll_mode), .i_otp_load(i_otp_load),
    .i_otp_sec_word(i_otp_sec_word), .i_all_paused(i_all_paused), .i_ring_osc(i_ring_osc),
    .o_ring_osc_en(o_ring_osc_en), .o_rgmii_txc(o_rgmii_txc), .o_rgmii_txd_launch(o_rgmii_txd_launch),
    .o_rgmii_txd_delay(o_rgmii_txd_delay), .o_rgmii_en(o_rgmii_en), .o_core_clk_en(o_core_clk_en),
    .o_usb_utmi_mode(o_usb_utmi_mode), .o_ulpi_helper_en(o_ulpi_helper_en),
    .o_global_debug_block(o_global_debug_block), .o_otp_sector_lock(o_otp_sector_lock),
    .o_otp_redundancy_en(o_otp_redundancy_en), .o_boot_from_otp(o_boot_from_otp),
    .o_jtag_cfg_block(o_jtag_cfg_block), .o_jtag_tap_block(o_jtag_tap_block));

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // The whole run needs under two hundred cycles; the ceiling leaves wide margin.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (e !== g) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic ps_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_ps_wr <= 1'b1;
    i_ps_addr <= a;
    i_ps_wdata <= d;
    @(posedge i_clk);
    i_ps_wr <= 1'b0;
    #1;
    refused = o_ps_wr_refused;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string name);
    @(posedge i_clk);
    i_ps_rd <= 1'b1;
    i_ps_addr <= a;
    @(posedge i_clk);
    i_ps_rd <= 1'b0;
    #1;
    check("rvalid", 32'h0000_0001, {31'h0, o_ps_rvalid});
    check(name, e, o_ps_rdata);
  endtask

  task automatic step;
    @(posedge i_clk);
    #1;
    k++;
    nl += o_rgmii_txd_launch;
  endtask

  task automatic lp_count(input logic [31:0] e, input string name);
    hi = 0;
    repeat (8) begin
      @(posedge i_clk);
      #1;
      hi += o_core_clk_en;
    end
    check(name, e, 32'(hi));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    i_por <= 1'b0;
    foreach (rows[i]) begin
      ps_write(rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].e, "row readback");
    end
    i_proc_num <= 8'h3C;
    i_boot_overwrite <= 1'b0;
    i_core1_off <= 1'b1;
    i_skip_otp_poll <= 1'b0;
    i_boot_ram <= 1'b1;
    i_boot_jtag <= 1'b0;
    rd_chk(8'h03, 32'h003C_012A & 32'hFFFF_FEFF, "boot status live");
    ps_write(8'h05, 32'h8000_0001);
    rd_chk(8'h05, 32'h8000_0001, "security locked");
    ps_write(8'h05, 32'h0000_0000);
    check("write refused", 32'h0000_0001, {31'h0, refused});
    rd_chk(8'h05, 32'h8000_0001, "security kept");
    @(posedge i_clk);
    i_otp_load <= 1'b1;
    i_otp_sec_word <= 32'hFFFF_F2F0;
    @(posedge i_clk);
    i_otp_load <= 1'b0;
    rd_chk(8'h05, 32'h8000_52B0, "otp copy");
    check("security outs", 32'h0000_01FE, sec_outs);
    ps_write(8'h02, 32'h0008_0700);
    k = 0;
    while (o_rgmii_txc !== 1'b0 && k < 20) step();
    while (o_rgmii_txc !== 1'b1 && k < 20) step();
    hi = 0;
    lo = 0;
    nl = 0;
    while (o_rgmii_txc === 1'b1 && k < 40) begin
      step();
      hi++;
    end
    while (o_rgmii_txc === 1'b0 && k < 40) begin
      step();
      lo++;
    end
    check("txc high", 32'h0000_0002, 32'(hi));
    check("txc low", 32'h0000_0002, 32'(lo));
    check("launches", 32'h0000_0001, 32'(nl));
    ps_write(8'h02, 32'h0000_0010);
    lp_count(32'h0000_0004, "static divide");
    ps_write(8'h02, 32'h0000_0030);
    lp_count(32'h0000_0008, "dynamic busy");
    i_all_paused <= 1'b1;
    lp_count(32'h0000_0004, "dynamic paused");
    ps_write(8'h06, 32'h0000_0002);
    check("core pair", 32'h0000_0003, {28'h0, o_ring_osc_en});
    ps_write(8'h06, 32'h0000_0003);
    repeat (5) begin
      @(posedge i_clk);
      i_ring_osc <= 4'hF;
      repeat (3) @(posedge i_clk);
      i_ring_osc <= 4'h0;
      repeat (3) @(posedge i_clk);
    end
    ps_write(8'h06, 32'h0000_0000);
    // Counts are read only once the oscillators have been stopped a while.
    repeat (12) @(posedge i_clk);
    for (int a = 7; a <= 10; a++) begin
      rd_chk(8'(a), 32'h0000_0005, "osc count");
    end
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(8'h07, 32'h0000_0005, "count kept");
    rd_chk(8'h02, 32'h0000_0000, "ctrl reset");
    rd_chk(8'h06, 32'h0000_0000, "roc reset");
    final_report();
  end
endmodule
